// *** hdl/tec_regs.vh ***
// Register map, field positions, reset values and encodings of the timer/event counter.
`ifndef TEC_REGS_VH
`define TEC_REGS_VH

`define TEC_ADDR_W 8
`define TEC_OFS_CONTROL 8'h00
`define TEC_OFS_DATA 8'h04

`define TEC_MODE_HI 7
`define TEC_MODE_LO 6
`define TEC_RSV_BIT 5
`define TEC_CNTEN_BIT 4
`define TEC_EDGE_BIT 3
`define TEC_PSC_HI 2
`define TEC_PSC_LO 0
`define TEC_PDIV_HI 4
`define TEC_PDIV_LO 2
`define TEC_SUBSEL_BIT 1
`define TEC_PWM_ENABLE_BIT 0

`define TEC_MODE_PWM 2'b00
`define TEC_MODE_EVENT 2'b01
`define TEC_MODE_TIMER 2'b10
`define TEC_MODE_PULSE 2'b11

`define TEC_CTRL_RESET 8'h00
`define TEC_DATA_RESET 8'h00
`define TEC_CTRL_WMASK 8'hDF
`define TEC_CNT_MAX 8'hFF
`define TEC_PSC_ALL 7'h7F
`define TEC_PSC_ONE 7'h01

`define TEC_PDIV_LIM_1 6'h00
`define TEC_PDIV_LIM_2 6'h01
`define TEC_PDIV_LIM_3 6'h02
`define TEC_PDIV_LIM_4 6'h03
`define TEC_PDIV_LIM_8 6'h07
`define TEC_PDIV_LIM_16 6'h0F
`define TEC_PDIV_LIM_32 6'h1F
`define TEC_PDIV_LIM_64 6'h3F

`endif

// *** hdl/tec_timer_event_counter_pwm.v ***
// Eight-bit timer, event counter, pulse width meter and PWM generator with an APB slave.

`include "tec_regs.vh"

module tec_timer_event_counter_pwm (
   input wire clk,
   input wire rst_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`TEC_ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire timebaseTick,
   input wire counterInputPin,
   input wire sleepMode,
   output reg overflowIrq,
   output reg wakeupReq,
   output reg pwmOut,
   output reg pwmOutInverted
);

   reg [7:0] control_r;
   reg [7:0] counter_r;
   reg [7:0] preload_r;
   reg [7:0] duty_r;
   reg [6:0] pscCnt_r;
   reg pinPrev_r;
   reg measuring_r;
   reg [5:0] pwmDivCnt_r;
   reg [7:0] pwmCnt_r;
   reg [5:0] pwmDivLim;
   reg pwmHigh;
   reg [7:0] readValue;
   reg addrOk;
   reg [6:0] pscMask;
   reg activeEdge;
   reg pulseStart;
   reg pulseEdgeEnd;
   reg countStep;
   reg [7:0] subIndex;
   reg [7:0] subPosition;
   reg [7:0] baseDuty;
   reg [7:0] dutyExtension;

   wire [1:0] modeSelect;
   wire countEnable;
   wire edgeSelect;
   wire [2:0] prescaleSelect;
   wire [2:0] pwmClockDivider;
   wire subcycleSelect;
   wire pwmEnable;
   wire isPwm;
   wire isEvent;
   wire isTimer;
   wire isPulse;
   wire accessFirst;
   wire accessDone;
   wire wrStrobe;
   wire ctrlWr;
   wire dataWr;
   wire prescaledTick;
   wire pinRise;
   wire pinFall;
   wire pulseStop;
   wire overflow;
   wire pwmRun;
   wire pwmTick;
   wire [7:0] highLength;

   // Both control views are one register; the mode field decides how bits 4..0 are read.
   assign modeSelect = control_r[`TEC_MODE_HI:`TEC_MODE_LO];
   assign countEnable = control_r[`TEC_CNTEN_BIT];
   assign edgeSelect = control_r[`TEC_EDGE_BIT];
   assign prescaleSelect = control_r[`TEC_PSC_HI:`TEC_PSC_LO];
   assign pwmClockDivider = control_r[`TEC_PDIV_HI:`TEC_PDIV_LO];
   assign subcycleSelect = control_r[`TEC_SUBSEL_BIT];
   assign pwmEnable = control_r[`TEC_PWM_ENABLE_BIT];

   assign isPwm = (modeSelect == `TEC_MODE_PWM);
   assign isEvent = (modeSelect == `TEC_MODE_EVENT);
   assign isTimer = (modeSelect == `TEC_MODE_TIMER);
   assign isPulse = (modeSelect == `TEC_MODE_PULSE);

   // The slave answers in the second access cycle; writes take effect at that edge.
   assign accessFirst = psel & penable & ~pready;
   assign accessDone = psel & penable & pready;
   assign wrStrobe = accessDone & pwrite;
   assign ctrlWr = wrStrobe & (paddr == `TEC_OFS_CONTROL);
   assign dataWr = wrStrobe & (paddr == `TEC_OFS_DATA);

   always @* begin
      addrOk = 1'b0;
      readValue = 8'h00;
      case (paddr)
         `TEC_OFS_CONTROL: begin
            addrOk = 1'b1;
            readValue = control_r & `TEC_CTRL_WMASK;
         end
         `TEC_OFS_DATA: begin
            addrOk = 1'b1;
            if (isPwm) begin
               readValue = duty_r;
            end else begin
               readValue = counter_r;
            end
         end
         default: begin
            addrOk = 1'b0;
            readValue = 8'h00;
         end
      endcase
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
      end else begin
         pready <= accessFirst;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= accessFirst & ~addrOk;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (accessFirst & ~pwrite) begin
         prdata <= {24'h00_0000, readValue};
      end else begin
         prdata <= 32'h0000_0000;
      end
   end

   // Free-running prescaler on the time base; a selected tick marks the falling edge of bit k-1.
   always @* begin
      case (prescaleSelect)
         3'b000: pscMask = 7'h00;
         3'b001: pscMask = 7'h01;
         3'b010: pscMask = 7'h03;
         3'b011: pscMask = 7'h07;
         3'b100: pscMask = 7'h0F;
         3'b101: pscMask = 7'h1F;
         3'b110: pscMask = 7'h3F;
         default: pscMask = 7'h7F;
      endcase
   end

   assign prescaledTick = timebaseTick & ((pscCnt_r | ~pscMask) == `TEC_PSC_ALL);

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pscCnt_r <= 7'h00;
      end else if (timebaseTick) begin
         pscCnt_r <= pscCnt_r + `TEC_PSC_ONE;
      end
   end

   // Edge detection on the external input pin.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pinPrev_r <= 1'b0;
      end else begin
         pinPrev_r <= counterInputPin;
      end
   end

   assign pinRise = counterInputPin & ~pinPrev_r;
   assign pinFall = ~counterInputPin & pinPrev_r;
   always @* begin
      if (edgeSelect) begin
         activeEdge = pinFall;
         pulseStart = pinRise;
         pulseEdgeEnd = pinFall;
      end else begin
         activeEdge = pinRise;
         pulseStart = pinFall;
         pulseEdgeEnd = pinRise;
      end
   end

   assign pulseStop = isPulse & countEnable & measuring_r & pulseEdgeEnd;

   // Pulse measurement arms on the start edge and ends on the opposite edge.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         measuring_r <= 1'b0;
      end else if (!isPulse || !countEnable) begin
         measuring_r <= 1'b0;
      end else if (!measuring_r && pulseStart) begin
         measuring_r <= 1'b1;
      end else if (pulseStop) begin
         measuring_r <= 1'b0;
      end
   end

   // Event mode uses only the pin; the prescaler is not looked at there.
   always @* begin
      countStep = 1'b0;
      if (~isPwm & countEnable) begin
         if (isEvent) begin
            countStep = activeEdge;
         end else if (isTimer) begin
            countStep = prescaledTick;
         end else if (isPulse) begin
            countStep = measuring_r & ~pulseStop & prescaledTick;
         end else begin
            countStep = 1'b0;
         end
      end
   end
   assign overflow = countStep & (counter_r == `TEC_CNT_MAX);

   // Control register; software writes win over the hardware clear of the enable bit.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         control_r <= `TEC_CTRL_RESET;
      end else if (ctrlWr) begin
         control_r <= pwdata[7:0] & `TEC_CTRL_WMASK;
      end else if (pulseStop) begin
         control_r[`TEC_CNTEN_BIT] <= 1'b0;
      end
   end

   // Data address writes the duty in PWM mode and the preload otherwise, plus the counter while counting is off.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         duty_r <= `TEC_DATA_RESET;
      end else if (dataWr && isPwm) begin
         duty_r <= pwdata[7:0];
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         preload_r <= `TEC_DATA_RESET;
      end else if (dataWr && !isPwm) begin
         preload_r <= pwdata[7:0];
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         counter_r <= `TEC_DATA_RESET;
      end else if (dataWr && !isPwm && !countEnable) begin
         counter_r <= pwdata[7:0];
      end else if (overflow) begin
         counter_r <= preload_r;
      end else if (countStep) begin
         counter_r <= counter_r + 8'h01;
      end
   end

   // Overflow and wake-up requests are one-cycle pulses; counting never depends on sleep.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         overflowIrq <= 1'b0;
      end else begin
         overflowIrq <= overflow;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wakeupReq <= 1'b0;
      end else begin
         wakeupReq <= overflow & sleepMode & (isEvent | isPulse);
      end
   end

   // PWM clock divider limit per code.
   always @* begin
      case (pwmClockDivider)
         3'b000: pwmDivLim = `TEC_PDIV_LIM_1;
         3'b001: pwmDivLim = `TEC_PDIV_LIM_2;
         3'b010: pwmDivLim = `TEC_PDIV_LIM_3;
         3'b011: pwmDivLim = `TEC_PDIV_LIM_4;
         3'b100: pwmDivLim = `TEC_PDIV_LIM_8;
         3'b101: pwmDivLim = `TEC_PDIV_LIM_16;
         3'b110: pwmDivLim = `TEC_PDIV_LIM_32;
         default: pwmDivLim = `TEC_PDIV_LIM_64;
      endcase
   end

   assign pwmRun = isPwm & pwmEnable;
   assign pwmTick = pwmRun & (pwmDivCnt_r >= pwmDivLim);

   // The divider and cycle counter restart from zero on enable, so the first cycle is exact here.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pwmDivCnt_r <= 6'h00;
      end else if (!pwmRun) begin
         pwmDivCnt_r <= 6'h00;
      end else if (pwmTick) begin
         pwmDivCnt_r <= 6'h00;
      end else begin
         pwmDivCnt_r <= pwmDivCnt_r + 6'h01;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pwmCnt_r <= 8'h00;
      end else if (!pwmRun) begin
         pwmCnt_r <= 8'h00;
      end else if (pwmTick) begin
         pwmCnt_r <= pwmCnt_r + 8'h01;
      end
   end

   // The eight-bit cycle counter splits into sub-cycle index and position within it.
   always @* begin
      if (subcycleSelect) begin
         subIndex = {7'h00, pwmCnt_r[7]};
         subPosition = {1'b0, pwmCnt_r[6:0]};
         baseDuty = {1'b0, duty_r[7:1]};
         dutyExtension = {7'h00, duty_r[0]};
      end else begin
         subIndex = {6'h00, pwmCnt_r[7:6]};
         subPosition = {2'b00, pwmCnt_r[5:0]};
         baseDuty = {2'b00, duty_r[7:2]};
         dutyExtension = {6'h00, duty_r[1:0]};
      end
   end

   assign highLength = baseDuty + {7'h00, (subIndex < dutyExtension)};

   // The duty register is compared live, so a write shows on the very next clock.
   always @* begin
      pwmHigh = subPosition < highLength;
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pwmOut <= 1'b0;
      end else begin
         pwmOut <= pwmRun & pwmHigh;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pwmOutInverted <= 1'b1;
      end else begin
         pwmOutInverted <= ~(pwmRun & pwmHigh);
      end
   end

endmodule // tec_timer_event_counter_pwm

// *** verification/tec_partner.sv ***
// Event source and PWM load facing the timer/event counter pins.
module tec_partner (
   input wire logic clk,
   output logic pin,
   input wire logic pwmOut,
   input wire logic pwmOutInverted
);
   timeunit 1ns;
   timeprecision 1ps;
   initial pin = 1'b1;
   task automatic setPin(input logic v);
      @(posedge clk);
      pin <= v;
   endtask
   task automatic toggles(input int n);
      repeat (n) begin
         setPin(~pin);
         repeat (3) @(posedge clk);
      end
   endtask
   task automatic measure(input int n, output int hi);
      hi = 0;
      repeat (n) begin
         @(posedge clk);
         hi += (pwmOut === 1'b1 && pwmOutInverted === 1'b0);
      end
   endtask
endmodule // tec_partner

// *** verification/tec_assertions.sv ***
// Checker of the timer/event counter port behaviour.
`include "tec_regs.vh"
module tec_assertions (
   input wire clk,
   input wire rst_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`TEC_ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire timebaseTick,
   input wire counterInputPin,
   input wire sleepMode,
   input wire overflowIrq,
   input wire wakeupReq,
   input wire pwmOut,
   input wire pwmOutInverted
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] ctrl_r;
   wire isCtrl = paddr == `TEC_OFS_CONTROL;
   wire pwmRun = ctrl_r[7:6] == `TEC_MODE_PWM && ctrl_r[0];
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) ctrl_r <= 8'h00;
      else if (psel && penable && pready && pwrite && isCtrl) ctrl_r <= pwdata[7:0];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence sSetup; psel && !penable; endsequence
   sequence sAccess; psel && penable; endsequence
   AST_WAIT: assert property (sSetup ##1 sAccess |=> pready) else $error("late answer");
   AST_ONE: assert property (pready |=> !pready) else $error("long ready");
   AST_ERR: assert property (pready |-> pslverr == !(isCtrl || paddr == `TEC_OFS_DATA))
      else $error("bad slave error");
   AST_IDLE: assert property (!pready |-> prdata == 32'h0) else $error("stray data");
   AST_RSV: assert property (pready && !pwrite && isCtrl |->
      !prdata[5] && prdata[31:8] == 24'h0) else $error("reserved bit set");
   AST_CTRL: assert property (pready && !pwrite && isCtrl |->
      {prdata[7:6], prdata[3:0]} == {ctrl_r[7:6], ctrl_r[3:0]}) else $error("control lost");
   AST_INV: assert property (pwmOutInverted == !pwmOut) else $error("pair not inverse");
   AST_OFF: assert property (!pwmRun ##1 !pwmRun |-> !pwmOut) else $error("output not low");
   AST_WAKE: assert property (wakeupReq |-> overflowIrq) else $error("lone wake-up");
endmodule // tec_assertions
bind tec_timer_event_counter_pwm tec_assertions chk (.clk(clk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .timebaseTick(timebaseTick),
   .counterInputPin(counterInputPin), .sleepMode(sleepMode), .overflowIrq(overflowIrq),
   .wakeupReq(wakeupReq), .pwmOut(pwmOut), .pwmOutInverted(pwmOutInverted));

// *** verification/tb_top.sv ***
// Self-checking testbench of the timer/event counter.
`include "tec_regs.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, tick = 0, sleepMode = 0;
   logic [7:0] paddr = 8'h00, duty;
   logic [31:0] pwdata = 32'h0, rng = 32'hBA80;
   logic [32:0] expQ[$];
   logic [2:0] k;
   wire [31:0] prdata;
   wire pready, pslverr, pin, irq, wake, pwm, pwmN;
   int err_total = 0, checked = 0, cyc = 0, irqs = 0, wakes = 0, hi, n, dv;
   tec_timer_event_counter_pwm dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timebaseTick(tick), .counterInputPin(pin), .sleepMode(sleepMode),
      .overflowIrq(irq), .wakeupReq(wake), .pwmOut(pwm), .pwmOutInverted(pwmN));
   tec_partner part (.clk(clk), .pin(pin), .pwmOut(pwm), .pwmOutInverted(pwmN));
   initial forever #2.5 clk = ~clk;
   function logic [31:0] rnd();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction
   task check(input logic [32:0] seen, input logic [32:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task conclude;
      $display("compares %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // A read pushes the expected {pslverr, prdata}; the watcher below compares it.
   task apb(input logic wr, input logic [7:0] a, input logic [32:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wr ? d[31:0] : 32'h0;
      if (!wr) expQ.push_back(d);
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) check({pslverr, prdata}, expQ.pop_front());
      irqs += (irq === 1'b1);
      wakes += (wake === 1'b1);
      cyc++;
      if (cyc == 90000) begin
         err_total++;
         conclude;
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      apb(0, `TEC_OFS_CONTROL, 33'h0);
      apb(1, `TEC_OFS_CONTROL, 33'hFF);
      apb(0, `TEC_OFS_CONTROL, 33'hDF);
      apb(1, `TEC_OFS_CONTROL, 33'h00);
      apb(0, 8'h08, 33'h100000000);
      $display("register test done");
      tick <= 1'b1;
      apb(1, `TEC_OFS_CONTROL, 33'h47);
      apb(1, `TEC_OFS_DATA, 33'hFD);
      sleepMode <= 1'b1;
      apb(1, `TEC_OFS_CONTROL, 33'h57);
      part.toggles(8);
      apb(1, `TEC_OFS_DATA, 33'h10);
      apb(0, `TEC_OFS_DATA, 33'hFE);
      apb(1, `TEC_OFS_CONTROL, 33'h5F);
      part.toggles(4);
      apb(0, `TEC_OFS_DATA, 33'h10);
      check(33'(irqs), 33'h2);
      check(33'(wakes), 33'h2);
      tick <= 1'b0;
      $display("event test done");
      k = 3'(rnd());
      n = int'(rnd() % 32) + 1;
      apb(1, `TEC_OFS_CONTROL, {25'h0, 5'h10, k});
      apb(1, `TEC_OFS_DATA, 33'h0);
      apb(1, `TEC_OFS_CONTROL, {25'h0, 5'h12, k});
      tick <= 1'b1;
      repeat (n << k) @(posedge clk);
      tick <= 1'b0;
      apb(1, `TEC_OFS_CONTROL, {25'h0, 5'h10, k});
      apb(0, `TEC_OFS_DATA, 33'(n));
      $display("timer test done");
      apb(1, `TEC_OFS_CONTROL, 33'hC0);
      apb(1, `TEC_OFS_DATA, 33'h0);
      apb(1, `TEC_OFS_CONTROL, 33'hD0);
      part.setPin(1'b0);
      repeat (4) @(posedge clk);
      tick <= 1'b1;
      repeat (n) @(posedge clk);
      tick <= 1'b0;
      repeat (4) @(posedge clk);
      part.setPin(1'b1);
      repeat (4) @(posedge clk);
      apb(0, `TEC_OFS_CONTROL, 33'hC0);
      tick <= 1'b1;
      part.toggles(2);
      tick <= 1'b0;
      apb(0, `TEC_OFS_DATA, 33'(n));
      sleepMode <= 1'b0;
      $display("pulse test done");
      for (int i = 0; i < 8; i++) begin
         k = 3'(i);
         dv = (i < 4) ? i + 1 : 1 << (i - 1);
         duty = 8'(rnd());
         apb(1, `TEC_OFS_CONTROL, 33'h00);
         apb(1, `TEC_OFS_DATA, {25'h0, duty});
         apb(1, `TEC_OFS_CONTROL, {28'h0, k, i[0], 1'b1});
         repeat (256 * dv) @(posedge clk);
         part.measure(256 * dv, hi);
         check(33'(hi), 33'(duty * dv));
      end
      apb(1, `TEC_OFS_CONTROL, 33'h00);
      repeat (3) @(posedge clk);
      check({32'h0, pwm}, 33'h0);
      $display("pwm test done");
      conclude;
   end
endmodule // tb_top
